/* File: hdl/pmc_link_if.sv */
// Purpose: pins between the configuration master and the receiving logic
// Assumes: clock and data lines pulled high when not driven
// Notes: resolved wires computed here from the enables
`timescale 1ns/1ps
interface pmc_link_if;
  logic ce_n;
  logic oe_rst_n;
  logic ext_clk;
  logic busy;
  logic slow_sel;
  logic [pmc_pkg::REV_W-1:0] revision_select;
  logic config_pulse_n;
  logic generated_config_clock_o;
  logic generated_config_clock_oe;
  logic [pmc_pkg::DATA_W-1:0] data_o;
  logic data_oe;
  logic generated_config_clock;
  logic [pmc_pkg::DATA_W-1:0] data;

  // external pull-ups
  assign generated_config_clock =
    generated_config_clock_oe ? generated_config_clock_o : 1'b1;
  assign data = data_oe ? data_o : {pmc_pkg::DATA_W{1'b1}};

  modport device (
    input ce_n, oe_rst_n, ext_clk, busy, slow_sel, revision_select,
    output config_pulse_n, generated_config_clock_o,
    output generated_config_clock_oe, data_o, data_oe
  );
  modport host (
    output ce_n, oe_rst_n, ext_clk, busy, slow_sel, revision_select,
    input config_pulse_n, generated_config_clock, data
  );
endinterface : pmc_link_if

/* File: hdl/pmc_loader_end.sv */
// Purpose: receiving end, controls enables and takes clocked data
// Assumes: clock and data from the link are asynchronous, synchronised
// Notes: source clock for the master made here by a divider
`timescale 1ns/1ps
module pmc_loader_end (
  input wire logic core_clk,
  input wire logic sys_rst,
  pmc_link_if.host link,
  input wire logic cfg_start,
  input wire logic cfg_stop,
  input wire logic cnt_reset_req,
  input wire logic [pmc_pkg::REV_W-1:0] rev_in,
  input wire logic slow_in,
  input wire logic busy_in,
  output logic [pmc_pkg::DATA_W-1:0] word_q,
  output logic word_stb,
  output logic pulse_seen,
  output logic ready
);
  localparam int unsigned SW = pmc_pkg::DATA_W + 2;

  ////////////////////////////////////////////////////////////////////////
  // synchronisers
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic gclk_q;
  logic pulse_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync1 <= {SW{1'b1}};
      sync2 <= {SW{1'b1}};
      gclk_q <= 1'b1;
      pulse_q <= 1'b1;
    end else begin
      sync1 <= {link.generated_config_clock, link.config_pulse_n, link.data};
      sync2 <= sync1;
      gclk_q <= sync2[SW-1];
      pulse_q <= sync2[SW-2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control
  pmc_pkg::pmc_host_state_t state;
  pmc_pkg::pmc_host_state_t next_state;
  logic [pmc_pkg::CNT_W-1:0] cnt;
  logic [pmc_pkg::CNT_W-1:0] next_cnt;
  logic [3:0] ext_cnt;
  logic [3:0] next_ext_cnt;
  logic ext_clk;
  logic next_ext_clk;
  logic ce_n;
  logic oe_rst_n;
  logic [pmc_pkg::REV_W-1:0] rev;
  logic [pmc_pkg::REV_W-1:0] next_rev;
  logic busy;
  logic slow;
  logic [pmc_pkg::DATA_W-1:0] next_word_q;
  logic next_word_stb;
  logic next_pulse_seen;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_ext_cnt = ext_cnt + 4'h1;
    next_ext_clk = ext_clk;
    if (ext_cnt == pmc_pkg::EXT_HALF - 4'h1) begin
      next_ext_cnt = 4'h0;
      next_ext_clk = !ext_clk;
    end
    // selection kept still while the pulse is low, see R6
    next_rev = (pulse_q && sync2[SW-2]) ? rev_in : rev;
    next_word_q = word_q;
    next_word_stb = 1'b0;
    next_pulse_seen = pulse_q && !sync2[SW-2];
    case (state)
      pmc_pkg::PMC_H_IDLE: begin
        if (cfg_start) begin
          next_state = pmc_pkg::PMC_H_RUN;
        end else if (cnt_reset_req) begin
          next_state = pmc_pkg::PMC_H_RST;
          next_cnt = pmc_pkg::CNT_RST_HOLD;
        end
      end
      pmc_pkg::PMC_H_RUN: begin
        if (sync2[SW-1] && !gclk_q) begin
          next_word_q = sync2[pmc_pkg::DATA_W-1:0];
          next_word_stb = 1'b1;
        end
        if (cfg_stop) begin
          next_state = pmc_pkg::PMC_H_HOLD;
          next_cnt = pmc_pkg::CNT_RST_HOLD;
        end else if (cnt_reset_req) begin
          // reset may cut a running load, see R8
          next_state = pmc_pkg::PMC_H_RST;
          next_cnt = pmc_pkg::CNT_RST_HOLD;
        end
      end
      pmc_pkg::PMC_H_HOLD, pmc_pkg::PMC_H_RST: begin
        // held the full time so the counters surely reset, see R7 R8
        if (cnt == pmc_pkg::CNT_ZERO) begin
          next_state = pmc_pkg::PMC_H_IDLE;
        end else begin
          next_cnt = cnt - pmc_pkg::CNT_ONE;
        end
      end
      default: begin
        next_state = pmc_pkg::PMC_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= pmc_pkg::PMC_H_IDLE;
      cnt <= pmc_pkg::CNT_ZERO;
      ext_cnt <= 4'h0;
      ext_clk <= 1'b0;
      ce_n <= 1'b1;
      oe_rst_n <= 1'b1;
      rev <= '0;
      busy <= 1'b0;
      slow <= 1'b0;
      word_q <= '0;
      word_stb <= 1'b0;
      pulse_seen <= 1'b0;
      ready <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      ext_cnt <= next_ext_cnt;
      ext_clk <= next_ext_clk;
      ce_n <= (next_state != pmc_pkg::PMC_H_RUN);
      oe_rst_n <= (next_state != pmc_pkg::PMC_H_RST);
      rev <= next_rev;
      busy <= busy_in;
      slow <= slow_in; // see R10
      word_q <= next_word_q;
      word_stb <= next_word_stb;
      pulse_seen <= next_pulse_seen;
      ready <= (next_state == pmc_pkg::PMC_H_IDLE);
    end
  end

  assign link.ce_n = ce_n;
  assign link.oe_rst_n = oe_rst_n;
  assign link.ext_clk = ext_clk;
  assign link.busy = busy;
  assign link.slow_sel = slow;
  assign link.revision_select = rev;
endmodule : pmc_loader_end

/* File: hdl/pmc_pkg.sv */
// Purpose: shared constants and types for the configuration master link
// Assumes: core_clk at 200 MHz
// Notes: hold and float times kept in ns, cycle counts derived from them
package pmc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned REV_W = 2;
  localparam int unsigned CNT_W = 9;

  // least times round up, longest times round down
  localparam int unsigned REV_HOLD_NS = 300;
  localparam int unsigned REV_HOLD_CYC =
    (REV_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_RST_HOLD_NS = 2000;
  localparam int unsigned CNT_RST_HOLD_CYC =
    (CNT_RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FLOAT_MAX_NS = 45;
  localparam int unsigned FLOAT_MAX_CYC = FLOAT_MAX_NS / CLK_PERIOD_NS;

  localparam logic [CNT_W-1:0] REV_HOLD = CNT_W'(REV_HOLD_CYC);
  localparam logic [CNT_W-1:0] CNT_RST_HOLD = CNT_W'(CNT_RST_HOLD_CYC);
  localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;

  localparam logic [3:0] RUNOUT_EDGES = 4'h8;

  // internal source half periods in core_clk cycles
  localparam logic [3:0] DIV_FAST = 4'h4;
  localparam logic [3:0] DIV_SLOW = 4'h8;
  // host-made external source half period
  localparam logic [3:0] EXT_HALF = 4'h6;

  // clock start delays, longer with decompression
  localparam logic [CNT_W-1:0] START_PLAIN_INT = 9'h010;
  localparam logic [CNT_W-1:0] START_PLAIN_EXT = 9'h020;
  localparam logic [CNT_W-1:0] START_DEC_INT = 9'h040;
  localparam logic [CNT_W-1:0] START_DEC_EXT = 9'h060;

  typedef enum logic [3:0] {
    PMC_D_IDLE = 4'h1,
    PMC_D_START = 4'h2,
    PMC_D_RUN = 4'h4,
    PMC_D_RUNOUT = 4'h8
  } pmc_dev_state_t;

  typedef enum logic [3:0] {
    PMC_H_IDLE = 4'h1,
    PMC_H_RUN = 4'h2,
    PMC_H_HOLD = 4'h4,
    PMC_H_RST = 4'h8
  } pmc_host_state_t;
endpackage : pmc_pkg

/* File: hdl/pmc_prom_end.sv */
// Purpose: configuration master end, drives clock and data to the loader
// Assumes: link pins asynchronous to core_clk, synchronised here
// Notes: data changes after falling edge, loader samples on rising
//
// Functional notes
// R1 - decompression: clock at half source rate
// R2 - decompression without data: clock parked high
// R3 - start delay longer with decompression, per source
// R4 - eight clocks after chip disable, then float
// R5 - start-load command drives pulse low for hold
// R6 - revision sampled while pulse low
// R7 - long chip disable resets address counters
// R8 - long reset low resets address counters
// R9 - data floats promptly on disable or reset
// R10 - loader picks slower clock when setup needs
// R11 - busy holds current word, no advance; the code does this in parallel mode (par_mode) only
`timescale 1ns/1ps
module pmc_prom_end (
  input wire logic core_clk,
  input wire logic sys_rst,
  pmc_link_if.device link,
  input wire logic decomp_en,
  input wire logic ext_src_sel,
  input wire logic par_mode,
  input wire logic term_count,
  input wire logic start_load,
  input wire logic [pmc_pkg::DATA_W-1:0] data_word,
  input wire logic data_ready,
  output logic data_take,
  output logic addr_reset,
  output logic [pmc_pkg::REV_W-1:0] rev_sampled,
  output logic rev_valid
);
  localparam int unsigned SW = pmc_pkg::REV_W + 5;

  ////////////////////////////////////////////////////////////////////////
  // synchronisers
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic ext_q;
  logic s_ce_n;
  logic s_oe;
  logic s_ext;
  logic s_busy;
  logic s_slow;
  logic [pmc_pkg::REV_W-1:0] s_rev;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync1 <= '0;
      sync2 <= '0;
      ext_q <= 1'b0;
    end else begin
      sync1 <= {link.ce_n, link.oe_rst_n, link.ext_clk, link.busy,
                link.slow_sel, link.revision_select};
      sync2 <= sync1;
      ext_q <= s_ext;
    end
  end

  assign {s_ce_n, s_oe, s_ext, s_busy, s_slow, s_rev} = sync2;

  ////////////////////////////////////////////////////////////////////////
  // source clock ticks
  logic [3:0] div_cnt;
  logic [3:0] next_div_cnt;
  logic [3:0] div_lim;
  logic half_tick;

  always_comb begin
    // slow option chosen by the loader side, see R10
    div_lim = s_slow ? pmc_pkg::DIV_SLOW : pmc_pkg::DIV_FAST;
    if (ext_src_sel) begin
      half_tick = s_ext ^ ext_q;
      next_div_cnt = 4'h0;
    end else begin
      half_tick = (div_cnt == div_lim - 4'h1);
      next_div_cnt = half_tick ? 4'h0 : div_cnt + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // main control
  pmc_pkg::pmc_dev_state_t state;
  pmc_pkg::pmc_dev_state_t next_state;
  logic phase;
  logic next_phase;
  logic gclk;
  logic next_gclk;
  logic gclk_oe;
  logic next_gclk_oe;
  logic [pmc_pkg::DATA_W-1:0] dout;
  logic [pmc_pkg::DATA_W-1:0] next_dout;
  logic dout_oe;
  logic next_dout_oe;
  logic adv_pend;
  logic next_adv_pend;
  logic next_data_take;
  logic [pmc_pkg::CNT_W-1:0] wait_cnt;
  logic [pmc_pkg::CNT_W-1:0] next_wait_cnt;
  logic [3:0] run_cnt;
  logic [3:0] next_run_cnt;
  logic enable;
  logic step;
  logic clk_run;

  always_comb begin
    enable = !s_ce_n && s_oe;
    next_phase = half_tick ? !phase : phase;
    // decompression divides the source by two, see R1
    step = decomp_en ? (half_tick && phase) : half_tick;
    next_state = state;
    next_gclk = gclk;
    next_gclk_oe = gclk_oe;
    next_dout = dout;
    next_dout_oe = dout_oe && enable; // see R9
    next_adv_pend = adv_pend;
    next_data_take = 1'b0;
    next_wait_cnt = wait_cnt;
    next_run_cnt = run_cnt;
    clk_run = 1'b0;
    case (state)
      pmc_pkg::PMC_D_IDLE: begin
        next_gclk_oe = 1'b0;
        next_gclk = 1'b1;
        if (enable) begin
          next_state = pmc_pkg::PMC_D_START;
          // start delay by mode and source, see R3
          case ({decomp_en, ext_src_sel})
            2'h0: next_wait_cnt = pmc_pkg::START_PLAIN_INT;
            2'h1: next_wait_cnt = pmc_pkg::START_PLAIN_EXT;
            2'h2: next_wait_cnt = pmc_pkg::START_DEC_INT;
            default: next_wait_cnt = pmc_pkg::START_DEC_EXT;
          endcase
        end
      end
      pmc_pkg::PMC_D_START: begin
        if (!enable) begin
          next_state = pmc_pkg::PMC_D_IDLE;
        end else if (wait_cnt == pmc_pkg::CNT_ZERO) begin
          next_state = pmc_pkg::PMC_D_RUN;
          next_gclk_oe = 1'b1;
          next_gclk = 1'b1;
          next_dout = data_word;
          next_dout_oe = 1'b1;
          next_data_take = 1'b1;
          next_adv_pend = 1'b0;
        end else begin
          next_wait_cnt = wait_cnt - pmc_pkg::CNT_ONE;
        end
      end
      pmc_pkg::PMC_D_RUN: begin
        if (!s_oe) begin
          next_state = pmc_pkg::PMC_D_IDLE;
          next_gclk_oe = 1'b0;
        end else if (s_ce_n) begin
          if (term_count) begin
            next_state = pmc_pkg::PMC_D_IDLE;
            next_gclk_oe = 1'b0;
          end else begin
            next_state = pmc_pkg::PMC_D_RUNOUT; // see R4
            next_run_cnt = pmc_pkg::RUNOUT_EDGES;
          end
        end else begin
          clk_run = 1'b1;
        end
      end
      pmc_pkg::PMC_D_RUNOUT: begin
        if (!s_oe || (run_cnt == 4'h0 && gclk)) begin
          next_state = pmc_pkg::PMC_D_IDLE; // see R4
          next_gclk_oe = 1'b0;
        end else begin
          clk_run = 1'b1;
        end
      end
      default: begin
        next_state = pmc_pkg::PMC_D_IDLE;
        next_gclk_oe = 1'b0;
        next_dout_oe = 1'b0;
      end
    endcase
    if (clk_run && step) begin
      if (gclk) begin
        // without decompressed data the clock stays parked high, see R2
        if (!decomp_en || data_ready) begin
          next_gclk = 1'b0;
          if (adv_pend && state == pmc_pkg::PMC_D_RUN) begin
            next_dout = data_word;
            next_data_take = 1'b1;
            next_adv_pend = 1'b0;
          end
        end
      end else begin
        next_gclk = 1'b1;
        // in parallel mode busy keeps the present word on the pins, see R11
        next_adv_pend = !(par_mode && s_busy);
        if (state == pmc_pkg::PMC_D_RUNOUT) begin
          next_run_cnt = run_cnt - 4'h1; // see R4
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      div_cnt <= 4'h0;
      state <= pmc_pkg::PMC_D_IDLE;
      phase <= 1'b0;
      gclk <= 1'b1;
      gclk_oe <= 1'b0;
      dout <= '0;
      dout_oe <= 1'b0;
      adv_pend <= 1'b0;
      data_take <= 1'b0;
      wait_cnt <= pmc_pkg::CNT_ZERO;
      run_cnt <= 4'h0;
    end else begin
      div_cnt <= next_div_cnt;
      state <= next_state;
      phase <= next_phase;
      gclk <= next_gclk;
      gclk_oe <= next_gclk_oe;
      dout <= next_dout;
      dout_oe <= next_dout_oe;
      adv_pend <= next_adv_pend;
      data_take <= next_data_take;
      wait_cnt <= next_wait_cnt;
      run_cnt <= next_run_cnt;
    end
  end

  assign link.generated_config_clock_o = gclk;
  assign link.generated_config_clock_oe = gclk_oe;
  assign link.data_o = dout;
  assign link.data_oe = dout_oe;

  ////////////////////////////////////////////////////////////////////////
  // address counter reset on long disable or reset
  logic [pmc_pkg::CNT_W-1:0] ce_hi_cnt;
  logic [pmc_pkg::CNT_W-1:0] next_ce_hi_cnt;
  logic [pmc_pkg::CNT_W-1:0] oe_lo_cnt;
  logic [pmc_pkg::CNT_W-1:0] next_oe_lo_cnt;
  logic next_addr_reset;

  always_comb begin
    // saturate so that one hold gives one reset pulse
    next_ce_hi_cnt = !s_ce_n ? pmc_pkg::CNT_ZERO :
      (ce_hi_cnt == pmc_pkg::CNT_RST_HOLD) ? ce_hi_cnt :
      ce_hi_cnt + pmc_pkg::CNT_ONE;
    next_oe_lo_cnt = s_oe ? pmc_pkg::CNT_ZERO :
      (oe_lo_cnt == pmc_pkg::CNT_RST_HOLD) ? oe_lo_cnt :
      oe_lo_cnt + pmc_pkg::CNT_ONE;
    next_addr_reset =
      (next_ce_hi_cnt == pmc_pkg::CNT_RST_HOLD &&
       ce_hi_cnt != pmc_pkg::CNT_RST_HOLD) || // see R7
      (next_oe_lo_cnt == pmc_pkg::CNT_RST_HOLD &&
       oe_lo_cnt != pmc_pkg::CNT_RST_HOLD); // see R8
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ce_hi_cnt <= pmc_pkg::CNT_ZERO;
      oe_lo_cnt <= pmc_pkg::CNT_ZERO;
      addr_reset <= 1'b0;
    end else begin
      ce_hi_cnt <= next_ce_hi_cnt;
      oe_lo_cnt <= next_oe_lo_cnt;
      addr_reset <= next_addr_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration pulse and revision sample
  logic [pmc_pkg::CNT_W-1:0] pulse_cnt;
  logic [pmc_pkg::CNT_W-1:0] next_pulse_cnt;
  logic pulse_n;
  logic next_pulse_n;
  logic [pmc_pkg::REV_W-1:0] next_rev_sampled;
  logic next_rev_valid;

  always_comb begin
    next_pulse_cnt = pulse_cnt;
    next_pulse_n = pulse_n;
    next_rev_sampled = rev_sampled;
    next_rev_valid = 1'b0;
    if (start_load && pulse_n) begin
      next_pulse_n = 1'b0; // see R5
      next_pulse_cnt = pmc_pkg::REV_HOLD;
    end else if (!pulse_n) begin
      if (pulse_cnt == pmc_pkg::CNT_ONE) begin
        // sampled at the end of the hold, so far end had it settled
        next_pulse_n = 1'b1;
        next_rev_sampled = s_rev; // see R6
        next_rev_valid = 1'b1;
      end
      next_pulse_cnt = pulse_cnt - pmc_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pulse_cnt <= pmc_pkg::CNT_ZERO;
      pulse_n <= 1'b1;
      rev_sampled <= '0;
      rev_valid <= 1'b0;
    end else begin
      pulse_cnt <= next_pulse_cnt;
      pulse_n <= next_pulse_n;
      rev_sampled <= next_rev_sampled;
      rev_valid <= next_rev_valid;
    end
  end

  assign link.config_pulse_n = pulse_n;
endmodule : pmc_prom_end

/* File: verif/pmc_link_chk.sv */
// Purpose: watches the link between master and loader for timing slips
// Assumes: one clock domain, core_clk, synchronous active-high reset
// Notes: edge counts are taken at the pins, so one extra edge is allowed
`timescale 1ns/1ps
module pmc_link_chk (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic term_count,
  input wire logic ce_n,
  input wire logic oe_rst_n,
  input wire logic [pmc_pkg::REV_W-1:0] revision_select,
  input wire logic config_pulse_n,
  input wire logic generated_config_clock_o,
  input wire logic generated_config_clock_oe,
  input wire logic data_oe
);
  logic prev_ce;
  logic prev_clk;
  logic [3:0] edge_cnt;
  logic [3:0] next_edge_cnt;
  logic [7:0] low_cnt;
  logic [7:0] next_low_cnt;
  logic [7:0] en_cnt;
  logic [7:0] next_en_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // counters saturate so a stuck pin cannot wrap into a pass
  always_comb begin
    next_edge_cnt = edge_cnt;
    if (ce_n && !prev_ce) begin
      next_edge_cnt = 4'h0;
    end else if (generated_config_clock_o && !prev_clk && edge_cnt != 4'hf) begin
      next_edge_cnt = edge_cnt + 4'h1;
    end
    next_low_cnt = config_pulse_n ? 8'h00 : low_cnt + {7'h00, low_cnt != 8'hff};
    next_en_cnt = (ce_n || !oe_rst_n) ? 8'h00 : en_cnt + {7'h00, en_cnt != 8'hff};
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prev_ce <= 1'b1;
      prev_clk <= 1'b1;
      edge_cnt <= 4'h0;
      low_cnt <= 8'h00;
      en_cnt <= 8'h00;
    end else begin
      prev_ce <= ce_n;
      prev_clk <= generated_config_clock_o;
      edge_cnt <= next_edge_cnt;
      low_cnt <= next_low_cnt;
      en_cnt <= next_en_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_clk_quiet;
    ($stable(generated_config_clock_o) || !generated_config_clock_oe) [*3];
  endsequence
  sequence s_pulse_end;
    $rose(config_pulse_n);
  endsequence

  property p_half_period;
    $changed(generated_config_clock_o) && generated_config_clock_oe &&
      $past(generated_config_clock_oe) |=> s_clk_quiet;
  endproperty
  property p_start_delay;
    $rose(generated_config_clock_oe) |-> en_cnt >= 8'd17 && en_cnt <= 8'd104;
  endproperty
  property p_runout;
    $fell(generated_config_clock_oe) && ce_n && oe_rst_n && !term_count |->
      (edge_cnt + {3'h0, $rose(generated_config_clock_o)}) inside {4'h8, 4'h9};
  endproperty
  property p_oe_cut;
    $fell(oe_rst_n) |-> ##[1:6] !generated_config_clock_oe;
  endproperty
  property p_pulse_hold;
    s_pulse_end |-> low_cnt >= 8'd60 && low_cnt <= 8'd64;
  endproperty
  property p_rev_frozen;
    !config_pulse_n && low_cnt >= 8'd4 |-> $stable(revision_select);
  endproperty
  property p_float_ce;
    $rose(ce_n) |-> ##[1:9] !data_oe;
  endproperty
  property p_float_oe;
    $fell(oe_rst_n) |-> ##[1:9] !data_oe;
  endproperty

  a_half_period: assert property (p_half_period) else $error("clock half period short");
  a_start_delay: assert property (p_start_delay) else $error("clock start delay off");
  a_runout: assert property (p_runout) else $error("run-out edge count off");
  a_oe_cut: assert property (p_oe_cut) else $error("clock not cut on reset");
  a_pulse_hold: assert property (p_pulse_hold) else $error("pulse low time off");
  a_rev_frozen: assert property (p_rev_frozen) else $error("revision moved in pulse");
  a_float_ce: assert property (p_float_ce) else $error("data not floated on disable");
  a_float_oe: assert property (p_float_oe) else $error("data not floated on reset");
endmodule : pmc_link_chk

/* File: verif/pmc_tb.sv */
// Purpose: drives both link ends through their user sides and checks them
// Assumes: inputs change at the falling edge of core_clk
// Notes: term_count raised once to show the run-out is skipped
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic decomp_en = 1'b0;
  logic ext_src_sel = 1'b0;
  logic par_mode = 1'b0;
  logic start_load = 1'b0;
  logic [7:0] data_word = 8'h00;
  logic data_ready = 1'b0;
  logic cfg_start = 1'b0;
  logic cfg_stop = 1'b0;
  logic cnt_reset_req = 1'b0;
  logic [1:0] rev_in = 2'h0;
  logic slow_in = 1'b0;
  logic busy_in = 1'b0;
  logic term_count = 1'b0;
  logic data_take;
  logic addr_reset;
  logic [1:0] rev_sampled;
  logic rev_valid;
  logic [7:0] word_q;
  logic word_stb;
  logic pulse_seen;
  logic ready;
  logic gclk;
  logic gclk_oe;
  logic [7:0] pins;
  int num_errors = 0;
  int cmp_count = 0;

  always #2.5 core_clk = ~core_clk;

  pmc_link_if pmc_link_if_inst ();
  assign gclk = pmc_link_if_inst.generated_config_clock;
  assign gclk_oe = pmc_link_if_inst.generated_config_clock_oe;
  assign pins = pmc_link_if_inst.data;

  pmc_prom_end pmc_prom_end_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .link(pmc_link_if_inst.device), .decomp_en(decomp_en),
    .ext_src_sel(ext_src_sel), .par_mode(par_mode), .term_count(term_count),
    .start_load(start_load), .data_word(data_word), .data_ready(data_ready),
    .data_take(data_take), .addr_reset(addr_reset),
    .rev_sampled(rev_sampled), .rev_valid(rev_valid));
  pmc_loader_end pmc_loader_end_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .link(pmc_link_if_inst.host), .cfg_start(cfg_start), .cfg_stop(cfg_stop),
    .cnt_reset_req(cnt_reset_req), .rev_in(rev_in), .slow_in(slow_in),
    .busy_in(busy_in), .word_q(word_q), .word_stb(word_stb),
    .pulse_seen(pulse_seen), .ready(ready));
  pmc_link_chk pmc_link_chk_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .term_count(term_count),
    .ce_n(pmc_link_if_inst.ce_n), .oe_rst_n(pmc_link_if_inst.oe_rst_n),
    .revision_select(pmc_link_if_inst.revision_select),
    .config_pulse_n(pmc_link_if_inst.config_pulse_n),
    .generated_config_clock_o(pmc_link_if_inst.generated_config_clock_o),
    .generated_config_clock_oe(pmc_link_if_inst.generated_config_clock_oe),
    .data_oe(pmc_link_if_inst.data_oe));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  // 0 start, 1 stop, 2 counter reset, 3 start-load; one cycle wide
  task automatic pulse_in(input int which);
    cfg_start = (which == 0);
    cfg_stop = (which == 1);
    cnt_reset_req = (which == 2);
    start_load = (which == 3);
    tick(1);
    cfg_start = 1'b0;
    cfg_stop = 1'b0;
    cnt_reset_req = 1'b0;
    start_load = 1'b0;
  endtask : pulse_in

  // 0 clock rises, 1 word takes, 2 counter resets, 3 pulse seen, 4 strobes
  task automatic count_ev(input int n, input int which, output int c);
    logic prev;
    c = 0;
    prev = gclk;
    repeat (n) begin
      tick(1);
      if (which == 0 && gclk === 1'b1 && prev === 1'b0) c++;
      if (which == 1 && data_take === 1'b1) c++;
      if (which == 2 && addr_reset === 1'b1) c++;
      if (which == 3 && pulse_seen === 1'b1) c++;
      if (which == 4 && word_stb === 1'b1) c++;
      prev = gclk;
    end
  endtask : count_ev

  task automatic wait_rise(output int t);
    logic prev;
    t = 0;
    do begin
      prev = gclk;
      tick(1);
      t++;
    end while (!(gclk === 1'b1 && prev === 1'b0) && t < 200);
  endtask : wait_rise

  // loader holds the 400-cycle gap itself, hence the long bound
  task automatic start_up(output int d);
    int k;
    k = 0;
    pulse_in(0);
    while (pmc_link_if_inst.ce_n !== 1'b0 && k < 500) begin
      tick(1);
      k++;
    end
    d = 0;
    while (pmc_link_if_inst.generated_config_clock_oe !== 1'b1 && d < 300) begin
      tick(1);
      d++;
    end
  endtask : start_up

  task automatic stop_run(input int which);
    int c;
    pulse_in(which);
    tick(12);
    check({8'h00, pins}, 16'h00ff);
    check({15'h0, gclk_oe}, {15'h0, which == 1 && !term_count});
    count_ev(420, 2, c);
    check(16'(c), 16'h0001);
    check({15'h0, ready}, 16'h0001);
  endtask : stop_run

  ////////////////////////////////////////////////////////////////////////////
  initial begin : watchdog
    repeat (30000) @(posedge core_clk);
    num_errors++;
    give_verdict();
  end

  initial begin : main
    int d;
    int p;
    int c;
    logic [3:0] half;
    logic [8:0] n_start;
    tick(2);
    sys_rst = 1'b0;
    tick(3);
    data_word = 8'ha5;
    data_ready = 1'b1;
    // every source and rate, plain and decompressed
    for (int m = 0; m < 6; m++) begin
      decomp_en = (m >= 3);
      ext_src_sel = (m == 2 || m == 5);
      slow_in = (m == 1 || m == 4);
      half = ext_src_sel ? pmc_pkg::EXT_HALF :
        (slow_in ? pmc_pkg::DIV_SLOW : pmc_pkg::DIV_FAST);
      n_start = ext_src_sel ?
        (decomp_en ? pmc_pkg::START_DEC_EXT : pmc_pkg::START_PLAIN_EXT) :
        (decomp_en ? pmc_pkg::START_DEC_INT : pmc_pkg::START_PLAIN_INT);
      tick(64);
      start_up(d);
      check(16'(d), 16'(n_start) + 16'h0004);
      wait_rise(p);
      wait_rise(p);
      check(16'(p), 16'(int'(half) * (decomp_en ? 4 : 2)));
      check({8'h00, word_q}, 16'h00a5);
      stop_run(1);
    end
    // decompressed clock parks high while no data is ready
    decomp_en = 1'b1;
    ext_src_sel = 1'b0;
    slow_in = 1'b0;
    start_up(d);
    data_ready = 1'b0;
    tick(40);
    check({15'h0, gclk}, 16'h0001);
    count_ev(100, 0, c);
    check(16'(c), 16'h0000);
    data_ready = 1'b1;
    count_ev(100, 0, c);
    check({15'h0, c >= 5}, 16'h0001);
    count_ev(64, 4, c);
    check({15'h0, c >= 3}, 16'h0001);
    stop_run(1);
    // busy freezes the word on the pins
    decomp_en = 1'b0;
    par_mode = 1'b1;
    start_up(d);
    busy_in = 1'b1;
    tick(20);
    data_word = 8'h3c;
    count_ev(64, 1, c);
    check(16'(c), 16'h0000);
    check({8'h00, pins}, 16'h00a5);
    busy_in = 1'b0;
    count_ev(64, 1, c);
    check({15'h0, c >= 4}, 16'h0001);
    check({8'h00, pins}, 16'h003c);
    stop_run(2);
    start_up(d);
    term_count = 1'b1;
    stop_run(1);
    term_count = 1'b0;
    par_mode = 1'b0;
    // start-load pulse, a second request while low is ignored
    for (int r = 0; r < 4; r++) begin
      rev_in = 2'(r);
      tick(70);
      pulse_in(3);
      count_ev(10, 3, p);
      check(16'(p), 16'h0001);
      rev_in = ~2'(r);
      tick(20);
      pulse_in(3);
      d = 32;
      while (rev_valid !== 1'b1 && d < 200) begin
        tick(1);
        d++;
      end
      check({14'h0, rev_sampled}, 16'(r));
      check({15'h0, d >= 60 && d <= 64}, 16'h0001);
    end
    give_verdict();
  end
endmodule : tb
